// *** shift_store_pkg.sv ***
// shared constants for the shift-and-store bus register
package shift_store_pkg;
    localparam int STAGES     = 8;     // shift chain length
    localparam int FIFO_DEPTH = 8;     // parallel word buffer depth
    localparam logic [7:0] CHAIN_RESET = 8'h00; // chain value after reset
    localparam logic [7:0] STORE_RESET = 8'h00; // latch value after reset
    localparam int SYNC_STAGES = 2;    // pin synchroniser depth
endpackage

// *** word_fifo_if.sv ***
// valid/ready carrier between the register and its word buffer
`timescale 1ns/100ps
interface word_fifo_if #(parameter int WIDTH = 8);
    logic             valid; // word offered
    logic             ready; // word accepted
    logic [WIDTH-1:0] data;  // word value
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// *** word_fifo.sv ***
// parameterised word FIFO with valid and ready on both sides
`timescale 1ns/100ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    word_fifo_if.sink inPort,
    output logic      outValid,
    input  wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    // pointer and count state in one struct
    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
    } fifo_state_t;
    fifo_state_t st_r, st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];    // storage words
    logic pushOk, popOk;              // handshakes this cycle

    assign inPort.ready = (st_r.count != (AW+1)'(DEPTH));
    assign outValid     = (st_r.count != '0);
    assign outData      = mem[st_r.rdPtr];
    assign pushOk = inPort.valid && inPort.ready;
    assign popOk  = outValid && outReady;

    // pointer and count update
    always_comb begin
        st_nxt = st_r;
        if (pushOk) st_nxt.wrPtr = AW'((st_r.wrPtr + 1'b1) % DEPTH);
        if (popOk)  st_nxt.rdPtr = AW'((st_r.rdPtr + 1'b1) % DEPTH);
        st_nxt.count = st_r.count + (AW+1)'(pushOk) - (AW+1)'(popOk);
    end

    // state register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) st_r <= '0;
        else       st_r <= st_nxt;
    end

    // storage write, no reset needed on data
    always_ff @(posedge ref_clk) begin
        if (pushOk) mem[st_r.wrPtr] <= inPort.data;
    end
endmodule // word_fifo

// *** shift_store_register.sv ***
// 8-stage shift register with storage latches and three-state outputs
// What this block does
// - eight serial stages shift data onward
// - shift only on rising clock edge
// - per-stage latch drives three-state output
// - strobe high: latches follow stages
// - strobe falling: latches hold values
// - enable high: outputs show latches
// - enable low: outputs high impedance
// - fast serial output on rising edge
// - delayed serial output on falling edge
`timescale 1ns/100ps
module shift_store_register (
    input  wire logic       ref_clk,       // system clock
    input  wire logic       reset,         // async, active high
    input  wire logic       shiftClk,      // serial clock pin
    input  wire logic       serialIn,      // serial data pin
    input  wire logic       strobe,        // latch strobe pin
    input  wire logic       outEnable,     // output enable pin
    output logic [7:0]      parOut,        // parallel output data
    output logic [7:0]      parOutEn,      // per-bit drive enable
    output logic            serial_out_fast, // cascade out, rising
    output logic            serialOutSlow, // cascade out, falling
    output logic            wordValid,     // buffered word valid
    input  wire logic       wordReady,     // buffered word taken
    output logic [7:0]      wordData       // buffered latch word
);
    // all state in one struct
    typedef struct packed {
        logic [1:0] clkSync;   // shift clock synchroniser
        logic [1:0] datSync;   // data synchroniser
        logic [1:0] stbSync;   // strobe synchroniser
        logic [1:0] oeSync;    // enable synchroniser
        logic       clkPrev;   // last synced clock, edge detect
        logic       stbPrev;   // last synced strobe
        logic [7:0] chain;     // shift stages
        logic [7:0] store;     // storage latches
        logic [7:0] pOut;      // registered output data
        logic [7:0] pEn;       // registered output enables
        logic       fastOut;   // fast cascade bit
        logic       slowOut;   // delayed cascade bit
        logic       pushPend;  // latch word waiting for buffer
    } reg_state_t;
    reg_state_t st_r, st_nxt;

    word_fifo_if #(.WIDTH(8)) fifoIn ();
    logic riseEdge, fallEdge, stbFall;

    assign riseEdge = st_r.clkSync[1] && !st_r.clkPrev;
    assign fallEdge = !st_r.clkSync[1] && st_r.clkPrev;
    assign stbFall  = !st_r.stbSync[1] && st_r.stbPrev;
    assign fifoIn.valid = st_r.pushPend;
    assign fifoIn.data  = st_r.store;

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        // pins pass two flops before use
        st_nxt.clkSync = {st_r.clkSync[0], shiftClk};
        st_nxt.datSync = {st_r.datSync[0], serialIn};
        st_nxt.stbSync = {st_r.stbSync[0], strobe};
        st_nxt.oeSync  = {st_r.oeSync[0], outEnable};
        st_nxt.clkPrev = st_r.clkSync[1];
        st_nxt.stbPrev = st_r.stbSync[1];
        if (riseEdge) begin
            st_nxt.chain = {st_r.chain[6:0], st_r.datSync[1]};
            // fast out, from last stage
            // takes the bit entering the last stage on this very rise,
            // so a cascaded part sees exactly eight stages per device
            st_nxt.fastOut = st_r.chain[6];
        end
        if (fallEdge) st_nxt.slowOut = st_r.fastOut;
        if (st_r.stbSync[1]) st_nxt.store = st_nxt.chain;
        // otherwise latch holds; fall queues a word
        if (stbFall) st_nxt.pushPend = 1'b1;
        else if (fifoIn.ready) st_nxt.pushPend = 1'b0;
        st_nxt.pOut = st_r.store;
        st_nxt.pEn  = {8{st_r.oeSync[1]}};
    end

    // single state register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.chain <= shift_store_pkg::CHAIN_RESET;
            st_r.store <= shift_store_pkg::STORE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // captured words buffered; with a full buffer a pending word is lost
    // once strobe high lets the latches follow the stages again
    word_fifo #(.WIDTH(8), .DEPTH(shift_store_pkg::FIFO_DEPTH)) uFifo (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .inPort   (fifoIn.sink),
        .outValid (wordValid),
        .outReady (wordReady),
        .outData  (wordData)
    );

    assign parOut          = st_r.pOut;
    assign parOutEn        = st_r.pEn;
    assign serial_out_fast = st_r.fastOut;
    assign serialOutSlow   = st_r.slowOut;
endmodule // shift_store_register

// *** shift_store_sva.sv ***
// port checker for the shift-and-store register
`timescale 1ns/100ps
module shift_store_sva (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       shiftClk,
    input wire logic       strobe,
    input wire logic       outEnable,
    input wire logic [7:0] parOut,
    input wire logic [7:0] parOutEn,
    input wire logic       serial_out_fast,
    input wire logic       serialOutSlow,
    input wire logic       wordValid,
    input wire logic       wordReady
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_hiz_off: assert property ($fell(outEnable) |-> ##[1:5]
        parOutEn == 8'h00) else $error("drive not released");
    chk_drive_on: assert property ($rose(outEnable) |-> ##[1:5]
        parOutEn == 8'hFF) else $error("drive not taken");
    chk_fast_idle: assert property (!shiftClk[*5] |=>
        $stable(serial_out_fast)) else $error("fast out moved");
    chk_slow_idle: assert property (shiftClk[*5] |=>
        $stable(serialOutSlow)) else $error("slow out moved");
    chk_slow_copy: assert property ($fell(shiftClk) |-> ##[3:5]
        serialOutSlow == serial_out_fast) else $error("slow not copy");
    chk_latch_hold: assert property ((!strobe && outEnable)[*5] |=>
        $stable(parOut)) else $error("latch moved");
    chk_last_stage: assert property ((strobe && !shiftClk)[*6]
        |-> parOut[7] == serial_out_fast) else $error("last stage");
    chk_word_wait: assert property (wordValid && !wordReady |=>
        wordValid) else $error("word dropped");
endmodule // shift_store_sva
bind shift_store_register shift_store_sva chk (.ref_clk, .reset,
    .shiftClk, .strobe, .outEnable, .parOut, .parOutEn,
    .serial_out_fast, .serialOutSlow, .wordValid, .wordReady);

// *** serial_source.sv ***
// serial source model driving data and shift clock pins
`timescale 1ns/100ps
module serial_source (
    input  wire logic ref_clk,
    output logic      shiftClk,
    output logic      serialIn
);
    initial begin
        shiftClk = 1'b0;
        serialIn = 1'b0;
    end
    // first bit sent ends in the last stage; clock high 4 cycles, low 5 between bits
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge ref_clk) serialIn <= b[i];
            repeat (4) @(posedge ref_clk);
            shiftClk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            shiftClk <= 1'b0;
        end
        // data no longer held, so show a changed level
        serialIn <= ~b[0];
    endtask
endmodule // serial_source

// *** tb.sv ***
// self-checking bench for the shift-and-store register
`timescale 1ns/100ps
module tb;
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic       strobe = 1'b0;
    logic       outEnable = 1'b0;
    logic       wordReady = 1'b0;
    logic       shiftClk, serialIn, fastOut, slowOut, wordValid;
    logic [7:0] parOut, parOutEn, wordData;
    int         fails = 0;
    int         compares = 0;
    int         cycles = 0;
    serial_source src (.ref_clk, .shiftClk, .serialIn);
    shift_store_register dut (.ref_clk, .reset, .shiftClk, .serialIn,
        .strobe, .outEnable, .parOut, .parOutEn, .serial_out_fast(fastOut),
        .serialOutSlow(slowOut), .wordValid, .wordReady, .wordData);
    initial forever #10 ref_clk = ~ref_clk;
    // hang guard, far above the run length
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // shift a byte with transparent latches and driven pins
    task automatic test_shift_latch();
        strobe <= 1'b1;
        outEnable <= 1'b1;
        src.send_byte(8'hA5);
        tick(8);
        check(parOut, 8'hA5);
        check(parOutEn, 8'hFF);
        check({7'h00, fastOut}, 8'h01);
        check({7'h00, slowOut}, 8'h01);
        strobe <= 1'b0;
        $display("shift and latch done");
    endtask
    // strobe low: latches must not follow
    task automatic test_hold();
        src.send_byte(8'h3C);
        tick(8);
        check(parOut, 8'hA5);
        check({7'h00, fastOut}, 8'h00);
        strobe <= 1'b1;
        tick(8);
        check(parOut, 8'h3C);
        strobe <= 1'b0;
        tick(8);
        $display("hold done");
    endtask
    // enable low releases every output bit
    task automatic test_hiz();
        outEnable <= 1'b0;
        tick(8);
        check(parOutEn, 8'h00);
        $display("high impedance done");
    endtask
    // buffer stalled so far: oldest word first
    task automatic test_buffer();
        check({7'h00, wordValid}, 8'h01);
        check(wordData, 8'hA5);
        wordReady <= 1'b1;
        tick(1);
        wordReady <= 1'b0;
        tick(4);
        check(wordData, 8'h3C);
        $display("word buffer done");
    endtask
    initial begin
        tick(2);
        reset <= 1'b0;
        test_shift_latch();
        test_hold();
        test_hiz();
        test_buffer();
        finish_test();
    end
endmodule // tb
